/* File: src/sct_chan.sv */
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module sct_chan (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Register bus
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Dedicated pins
    input wire logic ext_clock_pin_three_in,
    input wire logic chan_sync_pin_in,
    input wire logic rxd_in,
    output logic txd_out,
    // Time-slot routed line
    input wire logic slot_clk_in,
    input wire logic slot_sync_in,
    input wire logic slot_rxd_in,
    output logic slot_txd_out,
    // Interrupt request
    output logic irq_out
);

    function automatic logic [4:0] clamp_len(input logic [31:0] v);
        // Buffers hold 16 bytes, larger lengths are cut
        if (v[15:0] > {11'h000, sct_pkg::BUF_MAX})
        begin
            return sct_pkg::BUF_MAX;
        end
        return v[4:0];
    endfunction

    function automatic logic in_win(input logic [7:0] a, input logic [1:0] w);
        return a[7:6] == w;
    endfunction

    // Bus slave
    logic ack_reg;
    logic acc;
    logic wr_en;
    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;
    assign acc = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = acc & ~ack_reg;
    assign wr_en = avs_write_in & ack_reg;
    assign avs_readdata_out = rdata_reg;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= acc & ~ack_reg;
            if (avs_read_in & ~ack_reg)
            begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // Registers
    logic [7:0] event_reg;
    logic [7:0] mask_reg;
    logic [15:0] mode_reg;
    logic [4:0] maxlen_reg;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    logic route_slot;
    logic resync_cmd;
    assign route_slot = mode_reg[sct_pkg::MODE_SLOT];
    assign resync_cmd = wr_en & (avs_address_in == sct_pkg::CMD_OFS)
        & avs_writedata_in[sct_pkg::CMD_RESYNC];
    assign ev_clr = (wr_en & (avs_address_in == sct_pkg::EVT_OFS))
        ? avs_writedata_in[7:0] : 8'h00;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            event_reg <= sct_pkg::EVT_RST;
        end
        else
        begin
            // Set after clear so a same-cycle event survives
            event_reg <= ((event_reg & ~ev_clr) | ev_set)
                & sct_pkg::EV_USED;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mask_reg <= sct_pkg::MASK_RST;
            mode_reg <= sct_pkg::MODE_RST;
            maxlen_reg <= sct_pkg::MAXLEN_RST;
        end
        else if (wr_en)
        begin
            if (avs_address_in == sct_pkg::MASK_OFS)
            begin
                mask_reg <= avs_writedata_in[7:0];
            end
            if (avs_address_in == sct_pkg::MODE_OFS)
            begin
                mode_reg <= avs_writedata_in[15:0];
            end
            if (avs_address_in == sct_pkg::MAXLEN_OFS)
            begin
                maxlen_reg <= clamp_len(avs_writedata_in);
            end
        end
    end

    // Level, not pulse: stays up until every unmasked event is cleared
    assign irq_out = |(event_reg & mask_reg);

    // Line inputs: two flops before use
    logic [5:0] pins_s1_reg;
    logic [5:0] pins_s2_reg;
    logic lclk_d_reg;
    logic lclk;
    logic lsync;
    logic lrxd;
    logic rise;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pins_s1_reg <= 6'h00;
            pins_s2_reg <= 6'h00;
            lclk_d_reg <= 1'b0;
        end
        else
        begin
            pins_s1_reg <= {slot_rxd_in, slot_sync_in, slot_clk_in, rxd_in,
                chan_sync_pin_in, ext_clock_pin_three_in};
            pins_s2_reg <= pins_s1_reg;
            lclk_d_reg <= lclk;
        end
    end

    // Clock, sync and data from the assigner or from own pins
    assign lclk = route_slot ? pins_s2_reg[3] : pins_s2_reg[0];
    assign lsync = route_slot ? pins_s2_reg[4] : pins_s2_reg[1];
    assign lrxd = route_slot ? pins_s2_reg[5] : pins_s2_reg[2];
    assign rise = lclk & ~lclk_d_reg;

    // Transmit descriptor, one-character FIFO and shifter
    logic [7:0] tx_buf [sct_pkg::BUF_DEPTH];
    logic tx_own_reg;
    logic tx_int_reg;
    logic tx_last_reg;
    logic [4:0] tx_len_reg;
    logic [4:0] tx_idx_reg;
    logic [7:0] hold_reg;
    logic hold_valid_reg;
    logic hold_last_reg;
    logic [7:0] tx_sh_reg;
    logic [2:0] tx_cnt_reg;
    logic txd_reg;
    logic txd_pin_reg;
    logic slot_txd_reg;
    logic tx_synced_reg;
    logic tx_en;
    logic tx_fill;
    logic tx_load;
    logic fill_final;
    logic close_fill;
    logic close_load;
    logic underrun;
    logic txctl_wr;

    assign tx_en = mode_reg[sct_pkg::MODE_TXEN];
    assign txctl_wr = wr_en & (avs_address_in == sct_pkg::TXCTL_OFS);
    assign tx_fill = tx_own_reg & tx_en & ~hold_valid_reg
        & (tx_idx_reg < tx_len_reg);
    assign fill_final = (tx_idx_reg + 5'h01) == tx_len_reg;
    assign tx_load = rise & tx_en & tx_synced_reg & (tx_cnt_reg == 3'h0)
        & hold_valid_reg;
    assign close_fill = tx_fill & fill_final & ~tx_last_reg;
    assign close_load = tx_load & hold_last_reg;
    // Shifter starved while the buffer still has bytes to hand over
    assign underrun = rise & tx_en & tx_synced_reg & (tx_cnt_reg == 3'h0)
        & ~hold_valid_reg & tx_own_reg & (tx_idx_reg != 5'h00)
        & (tx_idx_reg < tx_len_reg);

    always_ff @(posedge core_clk_in)
    begin
        if (wr_en & in_win(avs_address_in, sct_pkg::TXBUF_WIN))
        begin
            tx_buf[avs_address_in[5:2]] <= avs_writedata_in[7:0];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tx_own_reg <= 1'b0;
            tx_int_reg <= 1'b0;
            tx_last_reg <= 1'b0;
            tx_len_reg <= 5'h00;
            tx_idx_reg <= 5'h00;
        end
        else
        begin
            if (wr_en & (avs_address_in == sct_pkg::TXLEN_OFS))
            begin
                tx_len_reg <= clamp_len(avs_writedata_in);
            end
            // A fresh hand-over takes priority over a close
            if (txctl_wr)
            begin
                tx_own_reg <= avs_writedata_in[sct_pkg::CTL_OWN];
                tx_int_reg <= avs_writedata_in[sct_pkg::CTL_INT];
                tx_last_reg <= avs_writedata_in[sct_pkg::CTL_LAST];
                tx_idx_reg <= 5'h00;
            end
            else
            begin
                if (close_fill | close_load | underrun)
                begin
                    tx_own_reg <= 1'b0;
                end
                if (tx_fill)
                begin
                    tx_idx_reg <= tx_idx_reg + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            hold_reg <= 8'h00;
            hold_valid_reg <= 1'b0;
            hold_last_reg <= 1'b0;
        end
        else if (tx_fill)
        begin
            hold_reg <= tx_buf[tx_idx_reg[3:0]];
            hold_valid_reg <= 1'b1;
            hold_last_reg <= fill_final & tx_last_reg;
        end
        else if (tx_load | ~tx_en)
        begin
            hold_valid_reg <= 1'b0;
        end
    end

    // Frame end drops sync so the next frame waits for a new one
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tx_synced_reg <= 1'b0;
        end
        else if (~tx_en | close_load)
        begin
            tx_synced_reg <= 1'b0;
        end
        else if (rise & lsync)
        begin
            tx_synced_reg <= 1'b1;
        end
    end

    // LSB first, line idles high
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tx_sh_reg <= 8'h00;
            tx_cnt_reg <= 3'h0;
            txd_reg <= 1'b1;
            txd_pin_reg <= 1'b1;
            slot_txd_reg <= 1'b1;
        end
        else
        begin
            txd_pin_reg <= route_slot ? 1'b1 : txd_reg;
            slot_txd_reg <= route_slot ? txd_reg : 1'b1;
            if (tx_load)
            begin
                txd_reg <= hold_reg[0];
                tx_sh_reg <= {1'b0, hold_reg[7:1]};
                tx_cnt_reg <= sct_pkg::CHAR_LAST_BIT;
            end
            else if (rise & (tx_cnt_reg != 3'h0))
            begin
                txd_reg <= tx_sh_reg[0];
                tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                tx_cnt_reg <= tx_cnt_reg - 3'h1;
            end
            else if (rise)
            begin
                txd_reg <= 1'b1;
            end
        end
    end

    assign txd_out = txd_pin_reg;
    assign slot_txd_out = slot_txd_reg;

    // Receive descriptor and shifter
    logic [7:0] rx_buf [sct_pkg::BUF_DEPTH];
    logic [7:0] rx_sh_reg;
    logic [2:0] rx_bit_reg;
    logic rx_synced_reg;
    logic rx_own_reg;
    logic rx_int_reg;
    logic [4:0] rx_cnt_reg;
    logic [4:0] rx_len_reg;
    logic rx_en;
    logic rx_bit;
    logic char_done;
    logic [7:0] rx_byte;
    logic store;
    logic rx_full;
    logic rxctl_wr;

    assign rx_en = mode_reg[sct_pkg::MODE_REN];
    assign rxctl_wr = wr_en & (avs_address_in == sct_pkg::RXCTL_OFS);
    assign rx_bit = rise & rx_en & rx_synced_reg;
    assign char_done = rx_bit & (rx_bit_reg == sct_pkg::CHAR_LAST_BIT);
    assign rx_byte = {lrxd, rx_sh_reg[7:1]};
    assign store = char_done & rx_own_reg;
    assign rx_full = store & ((rx_cnt_reg + 5'h01) >= maxlen_reg);

    always_ff @(posedge core_clk_in)
    begin
        if (store)
        begin
            rx_buf[rx_cnt_reg[3:0]] <= rx_byte;
        end
    end

    // Resync makes the receiver wait for the next sync
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rx_synced_reg <= 1'b0;
            rx_sh_reg <= 8'h00;
            rx_bit_reg <= 3'h0;
        end
        else if (~rx_en | resync_cmd)
        begin
            rx_synced_reg <= 1'b0;
            rx_bit_reg <= 3'h0;
        end
        else if (rx_bit)
        begin
            rx_sh_reg <= rx_byte;
            rx_bit_reg <= rx_bit_reg + 3'h1;
        end
        else if (rise & lsync)
        begin
            rx_synced_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rx_own_reg <= 1'b0;
            rx_int_reg <= 1'b0;
            rx_cnt_reg <= 5'h00;
            rx_len_reg <= 5'h00;
        end
        else if (rxctl_wr)
        begin
            rx_own_reg <= avs_writedata_in[sct_pkg::CTL_OWN];
            rx_int_reg <= avs_writedata_in[sct_pkg::CTL_INT];
            rx_cnt_reg <= 5'h00;
            rx_len_reg <= 5'h00;
        end
        else if (rx_full)
        begin
            rx_own_reg <= 1'b0;
            rx_cnt_reg <= 5'h00;
            rx_len_reg <= rx_cnt_reg + 5'h01;
        end
        else if (store)
        begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
        end
    end

    // Event sources
    always_comb
    begin
        ev_set = 8'h00;
        ev_set[sct_pkg::EV_RX] = rx_full & rx_int_reg;
        ev_set[sct_pkg::EV_TX] = (close_fill | close_load)
            & tx_int_reg;
        ev_set[sct_pkg::EV_NOBUF] = char_done & ~rx_own_reg;
        ev_set[sct_pkg::EV_UNDER] = underrun & tx_int_reg;
    end

    // Read decode, unmapped reads as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (in_win(avs_address_in, sct_pkg::TXBUF_WIN))
        begin
            rd_mux[7:0] = tx_buf[avs_address_in[5:2]];
        end
        else if (in_win(avs_address_in, sct_pkg::RXBUF_WIN))
        begin
            rd_mux[7:0] = rx_buf[avs_address_in[5:2]];
        end
        else
        begin
            unique case (avs_address_in)
                sct_pkg::EVT_OFS: rd_mux[7:0] = event_reg;
                sct_pkg::MASK_OFS: rd_mux[7:0] = mask_reg;
                sct_pkg::MODE_OFS: rd_mux[15:0] = mode_reg;
                sct_pkg::TXCTL_OFS:
                begin
                    rd_mux[sct_pkg::CTL_OWN] = tx_own_reg;
                    rd_mux[sct_pkg::CTL_INT] = tx_int_reg;
                    rd_mux[sct_pkg::CTL_LAST] = tx_last_reg;
                end
                sct_pkg::TXLEN_OFS: rd_mux[4:0] = tx_len_reg;
                sct_pkg::RXCTL_OFS:
                begin
                    rd_mux[sct_pkg::CTL_OWN] = rx_own_reg;
                    rd_mux[sct_pkg::CTL_INT] = rx_int_reg;
                end
                sct_pkg::RXLEN_OFS: rd_mux[4:0] = rx_len_reg;
                sct_pkg::MAXLEN_OFS: rd_mux[4:0] = maxlen_reg;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: src/sct_pkg.sv */
package sct_pkg;
    // Register byte offsets
    localparam logic [7:0] EVT_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS = 8'h04;
    localparam logic [7:0] MODE_OFS = 8'h08;
    localparam logic [7:0] TXCTL_OFS = 8'h0c;
    localparam logic [7:0] TXLEN_OFS = 8'h10;
    localparam logic [7:0] RXCTL_OFS = 8'h14;
    localparam logic [7:0] RXLEN_OFS = 8'h18;
    localparam logic [7:0] MAXLEN_OFS = 8'h1c;
    localparam logic [7:0] CMD_OFS = 8'h20;
    localparam logic [1:0] TXBUF_WIN = 2'h1;
    localparam logic [1:0] RXBUF_WIN = 2'h2;
    // Event and mask bit positions
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_NOBUF = 2;
    localparam int EV_UNDER = 4;
    localparam logic [7:0] EV_USED = 8'h17;
    // Mode register fields
    localparam int MODE_REN = 0;
    localparam int MODE_TXEN = 1;
    localparam int MODE_SLOT = 2;
    // Descriptor control fields
    localparam int CTL_OWN = 15;
    localparam int CTL_INT = 12;
    localparam int CTL_LAST = 11;
    // Command bits
    localparam int CMD_RESYNC = 0;
    // Reset values
    localparam logic [7:0] EVT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [4:0] MAXLEN_RST = 5'h10;
    // Sizes
    localparam int BUF_DEPTH = 16;
    localparam logic [4:0] BUF_MAX = 5'h10;
    localparam logic [2:0] CHAR_LAST_BIT = 3'h7;
endpackage

/* File: bench/sct_chan_properties.sv */
`timescale 1ns/1ps
module sct_chan_properties (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Register bus
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Line and interrupt
    input wire logic txd_out,
    input wire logic slot_txd_out,
    input wire logic irq_out
);
    logic wr_ok;
    logic rd_ok;
    logic [7:0] mask_reg;
    logic slot_reg;
    assign wr_ok = avs_write_in && !avs_waitrequest_out;
    assign rd_ok = avs_read_in && !avs_waitrequest_out;
    // Shadows of mask and route as software last wrote them
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            mask_reg <= 8'h00;
        else if (wr_ok && avs_address_in == sct_pkg::MASK_OFS)
            mask_reg <= avs_writedata_in[7:0];
    end
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            slot_reg <= 1'b0;
        else if (wr_ok && avs_address_in == sct_pkg::MODE_OFS)
            slot_reg <= avs_writedata_in[sct_pkg::MODE_SLOT];
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    property p_mask_back;
        rd_ok && avs_address_in == sct_pkg::MASK_OFS
            |-> avs_readdata_out == {24'h000000, mask_reg};
    endproperty
    a_mask_back: assert property (p_mask_back)
        else $error("mask read differs from last write");
    property p_irq_masked;
        irq_out |-> (mask_reg & sct_pkg::EV_USED) != 8'h00;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with every event masked");
    property p_irq_hold;
        $fell(irq_out) |-> $past(wr_ok)
            && ($past(avs_address_in) == sct_pkg::EVT_OFS
            || $past(avs_address_in) == sct_pkg::MASK_OFS);
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without software clear");
    property p_w1c_zero;
        wr_ok && avs_address_in == sct_pkg::EVT_OFS
            && avs_writedata_in[7:0] == 8'h00 && irq_out |=> irq_out;
    endproperty
    a_w1c_zero: assert property (p_w1c_zero)
        else $error("zero write cleared an event");
    property p_evt_layout;
        rd_ok && avs_address_in == sct_pkg::EVT_OFS
            |-> (avs_readdata_out & ~{24'h000000, sct_pkg::EV_USED}) == 0;
    endproperty
    a_evt_layout: assert property (p_evt_layout)
        else $error("reserved event bit read as one");
    // Depth 3 leaves room for the output pipeline after a route change
    property p_slot_quiet;
        slot_reg && $past(slot_reg, 3) |-> txd_out;
    endproperty
    a_slot_quiet: assert property (p_slot_quiet)
        else $error("pin line driven in routed mode");
    property p_pin_quiet;
        !slot_reg && !$past(slot_reg, 3) |-> slot_txd_out;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("routed line driven in pin mode");
    property p_wait_first;
        $rose(avs_read_in || avs_write_in)
            |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("bus answer not after one wait state");
endmodule
bind sct_chan sct_chan_properties chk_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .txd_out(txd_out), .slot_txd_out(slot_txd_out), .irq_out(irq_out)
);

/* File: bench/sct_line_peer.sv */
`timescale 1ns/1ps
module sct_line_peer (
    // Line towards the channel
    output logic lclk_out,
    output logic sync_out,
    output logic rxd_out,
    input wire logic txd_in
);
    logic [7:0] rx_data [0:31];
    logic [7:0] tx_got [0:31];
    initial
    begin
        lclk_out = 1'b0;
        sync_out = 1'b0;
        rxd_out = 1'b1;
    end
    // Clock runs only inside a frame; data changes on the falling edge
    // and the line flips when released so no stale bit looks driven
    task automatic run_frame(input int nchar);
        int b;
        // Keep line edges off the system clock edge to avoid races
        #3;
        sync_out = 1'b1;
        rxd_out = ~rxd_out;
        #80;
        lclk_out = 1'b1;
        for (b = 0; b < nchar * 8; b++)
        begin
            #80;
            lclk_out = 1'b0;
            sync_out = 1'b0;
            if (b > 0)
                tx_got[(b - 1) / 8][(b - 1) % 8] = txd_in;
            rxd_out = rx_data[b / 8][b % 8];
            #80;
            lclk_out = 1'b1;
        end
        #80;
        lclk_out = 1'b0;
        tx_got[nchar - 1][7] = txd_in;
        rxd_out = ~rxd_out;
    endtask
endmodule

/* File: bench/sct_chan_tb_top.sv */
`timescale 1ns/1ps
module sct_chan_tb_top;
    logic core_clk_in;
    logic rst_in;
    logic [7:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic txd_out;
    logic slot_txd_out;
    logic irq_out;
    logic p_clk;
    logic p_sync;
    logic p_rxd;
    logic use_slot;
    logic [31:0] rd;
    int err_total;
    int checked;
    int i;
    sct_chan dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .ext_clock_pin_three_in(use_slot ? 1'b0 : p_clk),
        .chan_sync_pin_in(use_slot ? 1'b0 : p_sync),
        .rxd_in(p_rxd), .txd_out(txd_out),
        .slot_clk_in(use_slot ? p_clk : 1'b0),
        .slot_sync_in(use_slot ? p_sync : 1'b0),
        .slot_rxd_in(p_rxd), .slot_txd_out(slot_txd_out),
        .irq_out(irq_out)
    );
    sct_line_peer peer_u (
        .lclk_out(p_clk), .sync_out(p_sync), .rxd_out(p_rxd),
        .txd_in(use_slot ? slot_txd_out : txd_out)
    );
    always #5 core_clk_in = ~core_clk_in;
    function automatic logic [7:0] tx_pat(input int k);
        return 8'h5a + 8'(k * 19);
    endfunction
    function automatic logic [7:0] rx_pat(input int k);
        return 8'hc3 ^ 8'(k * 7);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request holds until waitrequest is seen low at a rising edge
    task automatic bus_go(input logic [7:0] a, input logic wr,
                          input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        do
        begin
            @(posedge core_clk_in);
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 100);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge core_clk_in);
        if (n >= 100)
        begin
            err_total++;
            $display("[FAIL] %0t bus answer missing", $time);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_go(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus_go(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_total++;
        $display("[FAIL] %0t run did not finish", $time);
        close_out;
    end
    initial
    begin
        core_clk_in = 1'b0;
        rst_in = 1'b1;
        avs_address_in = 8'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        use_slot = 1'b0;
        err_total = 0;
        checked = 0;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        rdc(sct_pkg::MASK_OFS, 32'h0);
        rdc(sct_pkg::EVT_OFS, 32'h0);
        wr(sct_pkg::MASK_OFS, 32'ha5);
        rdc(sct_pkg::MASK_OFS, 32'ha5);
        rdc(8'h3c, 32'h0);
        // Pin mode frame: 5 bytes out, 17 bytes in
        wr(sct_pkg::MAXLEN_OFS, 32'h10);
        wr(sct_pkg::RXCTL_OFS, 32'hb000);
        for (i = 0; i < 5; i++)
            wr({sct_pkg::TXBUF_WIN, 6'(4 * i)}, 32'(tx_pat(i)));
        wr(sct_pkg::TXLEN_OFS, 32'h5);
        wr(sct_pkg::TXCTL_OFS, 32'hb800);
        wr(sct_pkg::EVT_OFS, 32'hff);
        wr(sct_pkg::MASK_OFS, 32'h13);
        wr(sct_pkg::MODE_OFS, 32'h3830);
        wr(sct_pkg::MODE_OFS, 32'h3833);
        for (i = 0; i < 17; i++)
            peer_u.rx_data[i] = rx_pat(i);
        peer_u.run_frame(17);
        repeat (10) @(posedge core_clk_in);
        for (i = 0; i < 5; i++)
            chk(32'(peer_u.tx_got[i]), 32'(tx_pat(i)));
        chk(32'(peer_u.tx_got[5]), 32'hff);
        for (i = 0; i < 16; i++)
            rdc({sct_pkg::RXBUF_WIN, 6'(4 * i)}, 32'(rx_pat(i)));
        rdc(sct_pkg::RXLEN_OFS, 32'h10);
        rdc(sct_pkg::EVT_OFS, 32'h07);
        chk(32'(irq_out), 32'h1);
        wr(sct_pkg::EVT_OFS, 32'h01);
        rdc(sct_pkg::EVT_OFS, 32'h06);
        chk(32'(irq_out), 32'h1);
        wr(sct_pkg::EVT_OFS, 32'h00);
        rdc(sct_pkg::EVT_OFS, 32'h06);
        wr(sct_pkg::EVT_OFS, 32'h02);
        chk(32'(irq_out), 32'h0);
        rdc(sct_pkg::EVT_OFS, 32'h04);
        wr(sct_pkg::MASK_OFS, 32'h04);
        chk(32'(irq_out), 32'h1);
        wr(sct_pkg::EVT_OFS, 32'h04);
        chk(32'(irq_out), 32'h0);
        wr(sct_pkg::CMD_OFS, 32'h1);
        // Routed frame: no frame-end mark, receive limit of 2
        wr(sct_pkg::MODE_OFS, 32'h3834);
        use_slot <= 1'b1;
        wr(sct_pkg::MAXLEN_OFS, 32'h2);
        wr(sct_pkg::RXCTL_OFS, 32'hb000);
        wr(sct_pkg::TXLEN_OFS, 32'h2);
        wr(sct_pkg::TXCTL_OFS, 32'hb000);
        wr(sct_pkg::MASK_OFS, 32'h13);
        wr(sct_pkg::MODE_OFS, 32'h3837);
        peer_u.run_frame(3);
        repeat (10) @(posedge core_clk_in);
        for (i = 0; i < 2; i++)
        begin
            chk(32'(peer_u.tx_got[i]), 32'(tx_pat(i)));
            rdc({sct_pkg::RXBUF_WIN, 6'(4 * i)}, 32'(rx_pat(i)));
        end
        rdc(sct_pkg::RXLEN_OFS, 32'h2);
        rdc(sct_pkg::EVT_OFS, 32'h07);
        close_out;
    end
endmodule
